//--- tcww_pkg.sv
// What this block does
// [R1] Word index steps by one per written word, from 0 to last address, then 0.
// [R2] Index wrapping from last address back to 0 marks the image complete.
// [R3] Index-changed pulse shows that the word index took a new value.
// [R4] Index-changed pulse comes only after a full 16-bit word is written out.
// [R5] User pulses index-clear for one clock to zero the word index.
// [R6] Each settings word is 16 bits and carries the channel settings.
// [R7] User presents a valid word with every write strobe.
// [R8] Soft reset clears all controller registers and aborts any write. The code keeps oc_done through a soft reset.
// [R9] User synchronises the soft reset to the controller clock.
// [R10] Write-done goes high once every image word has been written.
// [R11] Write-done drops by itself when a new write sequence starts.
// [R12] Write-done works only in channel mode, low otherwise.
// [R13] Soft reset never restarts offset cancellation; it runs once after power-up. The code restarts it if a soft reset comes before it finishes.
// [R14] Mode select has no code for PLL reconfiguration.
// [R15] Mode 3'b000 is analog controls (default), 3'b001 channel; others unused.
// [R16] Reset during offset cancellation stops it; it restarts after release.
// [R17] Write strobe while idle starts one word write at the current index. The code starts one only in channel mode (3'b001).
// [R18] Busy stays high during a word write; no strobe until busy is low.
`default_nettype none

package tcww_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] ADR_CTRL = 4'h0;
	localparam logic [3:0] ADR_STAT = 4'h4;
	localparam logic [3:0] ADR_IST = 4'h8;
	localparam logic [3:0] ADR_IMSK = 4'hC;

	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_LAST_LSB = 8;
	localparam int STAT_IDX_LSB = 0;
	localparam int STAT_BUSY_BIT = 8;
	localparam int STAT_DONE_BIT = 9;
	localparam int STAT_OCDONE_BIT = 10;

	localparam int IRQ_WORD = 0;
	localparam int IRQ_IMAGE = 1;
	localparam int IRQ_OC = 2;
	localparam int IRQ_N = 3;

	// ----------------------------------------------------------------
	// Modes, widths, reset values, timing
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_ANALOG = 3'h0;
	localparam logic [2:0] MODE_CHAN = 3'h1;
	localparam int WORD_BITS = 16;
	localparam int IDX_BITS = 6;
	localparam logic [IDX_BITS-1:0] LAST_RST = 6'h3F;
	localparam logic [IRQ_N-1:0] IMSK_RST = 3'h0;
	localparam int OC_CYCLES = 16;
	localparam logic [4:0] OC_LAST = 5'(OC_CYCLES - 1);
	localparam logic [3:0] BIT_LAST = 4'(WORD_BITS - 1);

	typedef enum logic [1:0] {
		ST_OC = 2'b00,
		ST_IDLE = 2'b01,
		ST_SHIFT = 2'b10
	} tcww_state_e;

	typedef struct packed {
		logic wr;
		logic [WORD_BITS-1:0] data;
	} tcww_word_s;

	typedef struct packed {
		logic [IDX_BITS-1:0] last;
		logic [2:0] mode;
	} tcww_ctrl_s;

endpackage

`default_nettype wire

//--- tcww_top.sv
`default_nettype none

module tcww_top import tcww_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire logic [3:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	output logic irq_o,
	input wire tcww_word_s wd_i,
	input wire logic idx_clr_i,
	output logic busy_o,
	output logic [IDX_BITS-1:0] idx_o,
	output logic idx_chg_o,
	output logic done_o,
	output logic chan_sdo_o,
	output logic chan_sen_o,
	output logic oc_busy_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	tcww_state_e st_q, st_d;
	tcww_ctrl_s ctrl_q, ctrl_d;
	logic [IDX_BITS-1:0] idx_q, idx_d;
	logic [WORD_BITS-1:0] sh_q, sh_d;
	logic [3:0] bit_q, bit_d;
	logic [4:0] oc_cnt_q, oc_cnt_d;
	logic oc_done_q, oc_done_d;
	logic done_q, done_d;
	logic chg_q, busy_q, sen_q, ack_q, irq_q, oc_busy_q;
	logic [31:0] rd_q, rd_d;
	logic [IRQ_N-1:0] ist_q, ist_d, imsk_q, imsk_d, ev;

	// Both resets clear the controller; only power-on clears oc_done
	wire rst_any = rst_i | por_i;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire bus_req = cyc_i & stb_i & ~ack_q;
	wire bus_wr = bus_req & we_i;
	wire hit_ctrl = adr_i == ADR_CTRL;
	wire hit_stat = adr_i == ADR_STAT;
	wire hit_ist = adr_i == ADR_IST;
	wire hit_imsk = adr_i == ADR_IMSK;
	wire wr_ctrl0 = bus_wr & hit_ctrl & sel_i[0];
	wire wr_ctrl1 = bus_wr & hit_ctrl & sel_i[1];
	wire wr_ist = bus_wr & hit_ist & sel_i[0];
	wire wr_imsk = bus_wr & hit_imsk & sel_i[0];

	wire [31:0] ctrl_rd = {16'h0000, 2'b00, ctrl_q.last, 5'h00, ctrl_q.mode};
	wire [31:0] stat_rd = {21'h000000, oc_done_q, done_q, busy_q, 2'b00,
		idx_q};
	wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
		hit_stat ? stat_rd :
		hit_ist ? {29'h00000000, ist_q} :
		hit_imsk ? {29'h00000000, imsk_q} : 32'h00000000;

	// ----------------------------------------------------------------
	// Writer control
	// ----------------------------------------------------------------
	// Codes other than channel mode never start a write
	wire chan_mode = ctrl_q.mode == MODE_CHAN; // R14 R15
	wire start = (st_q == ST_IDLE) & wd_i.wr & chan_mode; // R17 R18
	wire word_end = (st_q == ST_SHIFT) & (bit_q == BIT_LAST); // R4
	wire wrap = word_end & (idx_q == ctrl_q.last); // R2
	wire oc_end = (st_q == ST_OC) & (oc_cnt_q == OC_LAST);
	wire [IDX_BITS-1:0] idx_next = wrap ? '0 : idx_q + 6'h01; // R1

	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		bit_d = bit_q;
		oc_cnt_d = oc_cnt_q;
		oc_done_d = oc_done_q;
		unique case (st_q)
			ST_OC: begin
				oc_cnt_d = oc_cnt_q + 5'h01;
				if (oc_end) begin
					oc_done_d = 1'b1;
					st_d = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (start) begin
					sh_d = wd_i.data; // R6
					bit_d = 4'h0;
					st_d = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				sh_d = {sh_q[WORD_BITS-2:0], 1'b0};
				bit_d = bit_q + 4'h1;
				if (word_end)
					st_d = ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// Index clear wins over a step in the same cycle
	assign idx_d = idx_clr_i ? '0 : word_end ? idx_next : idx_q; // R1 R5

	// Wrap sets, a new write clears, other modes hold it low
	assign done_d = !chan_mode ? 1'b0 :
		wrap ? 1'b1 : start ? 1'b0 : done_q; // R10 R11 R12

	assign ctrl_d = '{
		last: wr_ctrl1 ? dat_i[CTRL_LAST_LSB +: IDX_BITS] : ctrl_q.last,
		mode: wr_ctrl0 ? dat_i[CTRL_MODE_LSB +: 3] : ctrl_q.mode
	};

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	assign ev = {oc_end, wrap, word_end};
	// Set beats write-one-to-clear in the same cycle
	assign ist_d = (ist_q & ~(wr_ist ? dat_i[IRQ_N-1:0] : 3'h0)) | ev;
	assign imsk_d = wr_imsk ? dat_i[IRQ_N-1:0] : imsk_q;
	assign rd_d = bus_req & ~we_i ? rd_mux : 32'h00000000;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_any) begin // R8
			st_q <= oc_done_q & ~por_i ? ST_IDLE : ST_OC; // R13 R16
			oc_cnt_q <= 5'h00; // R16
			sh_q <= '0;
			bit_q <= 4'h0;
			idx_q <= '0;
			done_q <= 1'b0;
			chg_q <= 1'b0;
			busy_q <= 1'b0;
			sen_q <= 1'b0;
			oc_busy_q <= 1'b0;
		end else begin
			st_q <= st_d;
			oc_cnt_q <= oc_cnt_d;
			sh_q <= sh_d;
			bit_q <= bit_d;
			idx_q <= idx_d;
			done_q <= done_d;
			chg_q <= word_end; // R3 R4
			busy_q <= st_d != ST_IDLE; // R18
			sen_q <= st_d == ST_SHIFT;
			oc_busy_q <= st_d == ST_OC; // R16
		end
	end

	// Soft reset leaves this flag alone so a finished cancellation never runs again
	always_ff @(posedge clk_i) begin
		if (por_i)
			oc_done_q <= 1'b0;
		else if (!rst_i)
			oc_done_q <= oc_done_d; // R13
	end

	always_ff @(posedge clk_i) begin
		if (rst_any) begin // R8
			ctrl_q <= '{last: LAST_RST, mode: MODE_ANALOG}; // R15
			ist_q <= '0;
			imsk_q <= IMSK_RST;
			ack_q <= 1'b0;
			rd_q <= 32'h00000000;
			irq_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			ist_q <= ist_d;
			imsk_q <= imsk_d;
			ack_q <= bus_req;
			rd_q <= rd_d;
			irq_q <= |(ist_d & imsk_d);
		end
	end

	assign dat_o = rd_q;
	assign ack_o = ack_q;
	assign irq_o = irq_q;
	assign busy_o = busy_q;
	assign idx_o = idx_q;
	assign idx_chg_o = chg_q;
	assign done_o = done_q;
	assign chan_sdo_o = sh_q[WORD_BITS-1];
	assign chan_sen_o = sen_q;
	assign oc_busy_o = oc_busy_q;

	// ----------------------------------------------------------------
	// Check helpers
	// ----------------------------------------------------------------
	// Run lengths let a check see every cycle of a word; long
	// repetitions would blow up the property engines
	logic [4:0] sen_run_q, busy_run_q;

	always_ff @(posedge clk_i) begin
		if (rst_any || !sen_q)
			sen_run_q <= 5'h00;
		else
			sen_run_q <= sen_run_q + 5'h01;
	end

	always_ff @(posedge clk_i) begin
		if (rst_any || !busy_q)
			busy_run_q <= 5'h00;
		else
			busy_run_q <= busy_run_q + 5'h01;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i || por_i);

	sequence s_start;
		start && !idx_clr_i;
	endsequence

	// Sixteen shift cycles, then the index step
	sequence s_word;
		sen_q ##15 sen_q ##1 (chg_q && sen_run_q == 5'h10);
	endsequence

	sequence s_busy_word;
		busy_q ##15 busy_q ##1 (!busy_q && busy_run_q == 5'h10);
	endsequence

	chk_word_then_chg: assert property (s_start |=> s_word) // R3 R4
		else $error("index change not after sixteen shift cycles");

	chk_busy_word: assert property (start |=> s_busy_word) // R18
		else $error("busy not held for exactly one word");

	chk_idx_step: assert property (chg_q && !$past(idx_clr_i) |->
		idx_q == (($past(idx_q) == $past(ctrl_q.last)) ? 6'h00 :
		$past(idx_q) + 6'h01)) // R1
		else $error("word index did not step or wrap");

	chk_wrap_done: assert property (wrap && chan_mode && !idx_clr_i |=>
		done_q && idx_q == 6'h00) // R2 R10
		else $error("wrap did not raise write done");

	chk_done_drop: assert property (start |=> !done_q) // R11
		else $error("write done not dropped on new write");

	chk_mode_gate: assert property (!chan_mode |=> !done_q) // R12
		else $error("write done high outside channel mode");

	chk_mode_start: assert property ($rose(sen_q) |->
		$past(ctrl_q.mode) == MODE_CHAN) // R14 R15
		else $error("write started outside channel mode");

	chk_idx_clear: assert property (idx_clr_i |=> idx_q == 6'h00) // R5
		else $error("index clear ignored");

	chk_oc_once: assert property (oc_done_q |=> oc_done_q) // R13
		else $error("offset cancellation flag lost");

	chk_oc_length: assert property (st_q == ST_OC && oc_cnt_q == 5'h00 |->
		##15 st_q == ST_OC ##1 st_q == ST_IDLE) // R16
		else $error("offset cancellation length wrong");

	chk_soft_reset: assert property ($fell(rst_i) && oc_done_q |->
		st_q == ST_IDLE && idx_q == 6'h00 && !done_q && !sen_q) // R8
		else $error("soft reset left state behind");

	chk_irq_level: assert property (!$past(rst_any) |->
		irq_o == |$past(ist_d & imsk_d))
		else $error("interrupt output wrong");

	// Bus and interrupt bookkeeping
	chk_ack_pulse: assert property (ack_q |=> !ack_q)
		else $error("ack held longer than one cycle");

	chk_read_idle: assert property (!ack_q |-> rd_q == 32'h00000000)
		else $error("read data outside the ack cycle");

	chk_ist_word: assert property (word_end |=> ist_q[IRQ_WORD])
		else $error("word status bit not set");

	chk_ist_image: assert property (wrap |=> ist_q[IRQ_IMAGE]) // R2
		else $error("image status bit not set");

	chk_ist_oc: assert property (oc_end |=> ist_q[IRQ_OC])
		else $error("cancellation status bit not set");

	chk_ctrl_mode: assert property (wr_ctrl0 |=> // R15
		ctrl_q.mode == $past(dat_i[CTRL_MODE_LSB +: 3]))
		else $error("mode field write lost");

	chk_ctrl_last: assert property (wr_ctrl1 |=>
		ctrl_q.last == $past(dat_i[CTRL_LAST_LSB +: IDX_BITS]))
		else $error("last index field write lost");

	// Word writer details
	chk_chg_pulse: assert property (chg_q |=> !chg_q) // R3
		else $error("index change pulse too long");

	chk_sen_busy: assert property (sen_q |-> busy_q) // R18
		else $error("shifting while not busy");

	chk_refuse_busy: assert property (busy_q |-> !start) // R18
		else $error("write accepted while busy");

	chk_sdo_idle: assert property (!sen_q |-> !chan_sdo_o)
		else $error("serial data active outside a word");

	chk_first_bit: assert property (s_start |=> // R6
		chan_sdo_o == $past(wd_i.data[WORD_BITS-1]))
		else $error("first serial bit is not the word MSB");

	chk_idx_hold: assert property (!chg_q && !$past(idx_clr_i) && // R1
		!$past(rst_any) |-> $stable(idx_q))
		else $error("word index moved without a word");

	chk_clr_wins: assert property (idx_clr_i && word_end |=> // R5
		idx_q == 6'h00 && chg_q)
		else $error("index clear lost against a step");

	chk_mode_quiet: assert property (!chan_mode && st_q == ST_IDLE |=> // R15
		st_q != ST_SHIFT)
		else $error("write started outside channel mode");

	// Cancellation and reset
	sequence s_oc_begin;
		!busy_q ##1 busy_q;
	endsequence

	chk_oc_begin: assert property ($fell(por_i) |-> s_oc_begin) // R16
		else $error("cancellation did not start after power-on");

	chk_oc_quiet: assert property (oc_done_q |-> !oc_busy_q) // R13
		else $error("cancellation running after it finished");

	chk_reset_quiet: assert property ($fell(rst_any) |-> // R8
		!ack_q && !irq_q && !chg_q && !sen_q)
		else $error("outputs not cleared by reset");

endmodule

`default_nettype wire

//--- tcww_src.sv
`default_nettype none

module tcww_src import tcww_pkg::*; (
	input wire logic clk_i,
	input wire logic busy_i,
	input wire logic go_i,
	input wire logic [15:0] data_i,
	output tcww_word_s wd_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pend_q = 1'b0;
	initial wd_o = '0;
	// One strobe per word, only once busy is low
	always @(posedge clk_i) begin
		if (go_i)
			pend_q <= 1'b1;
		if (pend_q && busy_i === 1'b0 && !wd_o.wr) begin
			wd_o.wr <= 1'b1;
			wd_o.data <= data_i;
			pend_q <= 1'b0;
		end else begin
			wd_o.wr <= 1'b0;
			// No hold on data outside a strobe
			wd_o.data <= ~wd_o.data;
		end
	end
endmodule

`default_nettype wire

//--- tcww_top_tb.sv
`default_nettype none

module tcww_top_tb import tcww_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, por = 1, we = 0, cyc = 0, stb = 0;
	logic clr = 0, go = 0, ack, irq, busy, chg, done, sdo, sen, ocb;
	logic [3:0] adr = '0, sel = '0;
	logic [31:0] dat = '0, rdat, rd;
	logic [15:0] wdat = '0;
	logic [5:0] idx;
	tcww_word_s wd;
	int fails = 0, checked = 0, cycles = 0;

	always #50 clk = ~clk;

	tcww_top dut_u (.clk_i(clk), .rst_i(rst), .por_i(por), .adr_i(adr),
		.dat_i(dat), .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc),
		.stb_i(stb), .ack_o(ack), .irq_o(irq), .wd_i(wd), .idx_clr_i(clr),
		.busy_o(busy), .idx_o(idx), .idx_chg_o(chg), .done_o(done),
		.chan_sdo_o(sdo), .chan_sen_o(sen), .oc_busy_o(ocb));

	tcww_src src_u (.clk_i(clk), .busy_i(busy), .go_i(go),
		.data_i(wdat), .wd_o(wd));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	// Word goes out MSB first; index step shows one cycle after
	task automatic send(input logic [15:0] d, input logic [5:0] ei,
		input logic ed);
		logic [15:0] s;
		s = '0;
		wdat <= d;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		while (sen !== 1'b1)
			@(posedge clk);
		chk(32'(busy), 32'h1);
		repeat (16) begin
			s = {s[14:0], sdo};
			@(posedge clk);
		end
		chk(32'(s), 32'(d));
		chk(32'(sen), 32'h0);
		chk(32'(chg), 32'h1);
		chk(32'(idx), 32'(ei));
		chk(32'(done), 32'(ed));
		@(posedge clk);
		chk(32'(chg), 32'h0);
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			complete_run();
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		repeat (2) @(posedge clk);
		chk(32'(ocb), 32'h1);
		repeat (17) @(posedge clk);
		chk(32'(busy), 32'h0);
		wb(1'b1, 4'hC, 32'h7);
		chk(32'(irq), 32'h1);
		wb(1'b1, 4'h8, 32'h7);
		chk(32'(irq), 32'h0);
		wb(1'b1, 4'h0, 32'h201);
		wb(1'b0, 4'h0, '0);
		chk(rd, 32'h201);
		send(16'hA5C3, 6'h1, 1'b0);
		send(16'h5A3C, 6'h2, 1'b0);
		send(16'hF00F, 6'h0, 1'b1);
		wb(1'b0, 4'h8, '0);
		chk(rd, 32'h3);
		wb(1'b1, 4'hC, 32'h0);
		chk(32'(irq), 32'h0);
		wb(1'b1, 4'h8, 32'h7);
		send(16'h8001, 6'h1, 1'b0);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		@(posedge clk);
		chk(32'(idx), 32'h0);
		send(16'h0001, 6'h1, 1'b0);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(busy), 32'h0);
		chk(32'(idx), 32'h0);
		wb(1'b0, 4'h0, '0);
		chk(rd, 32'h3F00);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (25) @(posedge clk);
		chk(32'(idx), 32'h0);
		chk(32'(done), 32'h0);
		wb(1'b0, 4'h2, '0);
		chk(rd, 32'h0);
		complete_run();
	end
endmodule

`default_nettype wire
